// file: dv/rdoc_rx_detect_cfg_bench.sv
// self-checking bench for the receiver-detect configuration block
`timescale 1ns/100ps
`include "rdoc_consts.vh"
module rdoc_rx_detect_cfg_bench;
   // short counts keep the run brief
   localparam TC = 20;
   localparam GT = 3;
   // expected swing, emphasis and threshold codes by strap index
   localparam [63:0] SW = 64'hDDDD_CCCB_BBAA_A998;
   localparam [31:0] EM = 32'hE492_4910;
   localparam [7:0] TH = 8'hC6;
   // design inputs, all valued at time zero
   reg core_clk = 1'b0, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   reg [7:0] wb_adr_i = 8'h00;
   reg [3:0] wb_sel_i = 4'h1;
   reg [31:0] wb_dat_i = 32'h0000_0000;
   reg [1:0] swing_strap_group_a_high = 2'h0, swing_strap_group_a_low = 2'h0;
   reg [1:0] swing_strap_group_b_high = 2'h0, swing_strap_group_b_low = 2'h0;
   reg [1:0] driver_mode_strap = 2'h3, detect_strap = 2'h0, signal_sense_threshold_strap = 2'h2;
   reg power_down_pin = 1'b0, register_mode_select = 1'b0, present = 1'b0;
   // design outputs and bench state
   wire [31:0] wb_dat_o;
   wire wb_ack_o, rx_present, rx_test_q, term_50_q, input_hiz_q, driver_en_q;
   wire [3:0] output_swing_a_q, output_swing_b_q;
   wire [1:0] output_emphasis_reduction_a_q, output_emphasis_reduction_b_q, signal_sense_threshold_strap_code_q;
   wire [7:0] tests, gap;
   integer err_count = 0, checked = 0, i, n;
   reg [31:0] rd;
   reg [7:0] t0;
   rdoc_rx_detect_cfg #(.TEST_CYC(TC), .GIVEUP_TESTS(GT)) i_rdoc_rx_detect_cfg (
      .core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .swing_strap_group_a_high, .swing_strap_group_a_low,
      .swing_strap_group_b_high, .swing_strap_group_b_low, .driver_mode_strap,
      .detect_strap, .signal_sense_threshold_strap, .power_down_pin,
      .register_mode_select, .rx_present, .rx_test_q, .term_50_q, .input_hiz_q,
      .driver_en_q, .output_swing_a_q, .output_emphasis_reduction_a_q, .output_swing_b_q,
      .output_emphasis_reduction_b_q, .signal_sense_threshold_strap_code_q);
   rdoc_rx_partner i_rdoc_rx_partner (.core_clk, .rst_b, .rx_test_q, .present,
      .rx_present, .tests, .gap);
   // 10 mhz clock
   initial forever #50 core_clk = ~core_clk;
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wt(input integer k);
      repeat (k) @(negedge core_clk);
   endtask
   // one wishbone cycle; ack and read data are taken at the rising edge
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge core_clk);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         n = 0;
         @(posedge core_clk);
         while (wb_ack_o !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge core_clk);
         end
         if (n == 20)
            err_count = err_count + 1;
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
      end
   endtask
   // power-down pulse of 6 us, new detect code applied meanwhile
   task pdp(input [1:0] code);
      begin
         @(posedge core_clk);
         power_down_pin <= 1'b1;
         detect_strap <= code;
         wt(60);
         chk(input_hiz_q, 1'b1);
         chk(driver_en_q, 1'b0);
         @(posedge core_clk);
         power_down_pin <= 1'b0;
      end
   endtask
   task wtest(input [7:0] k);
      for (n = 0; tests < k && n < 2000; n = n + 1)
         @(negedge core_clk);
   endtask
   task give_verdict;
      begin
         $display("checked %0d mismatches %0d", checked, err_count);
         if (err_count == 0 && checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // watchdog, far beyond the thousand or so cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count = err_count + 1;
      give_verdict;
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      for (i = 0; i < 16; i = i + 1) begin
         @(posedge core_clk);
         {swing_strap_group_a_high, swing_strap_group_a_low} <= i[3:0];
         {swing_strap_group_b_high, swing_strap_group_b_low} <= 4'hf - i[3:0];
         wt(2);
         chk(output_swing_a_q, SW[i*4+:4]);
         chk(output_emphasis_reduction_a_q, EM[i*2+:2]);
         chk(output_swing_b_q, SW[(15-i)*4+:4]);
         chk(output_emphasis_reduction_b_q, EM[(15-i)*2+:2]);
      end
      @(posedge core_clk);
      driver_mode_strap <= 2'h1;
      wt(2);
      chk(output_emphasis_reduction_a_q, 2'h0);
      $display("test swing done");
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge core_clk);
         signal_sense_threshold_strap <= i[1:0];
         wt(2);
         chk(signal_sense_threshold_strap_code_q, TH[i*2+:2]);
      end
      $display("test threshold done");
      wt(3 * TC);
      chk(tests, 8'h00);
      chk(term_50_q, 1'b0);
      @(posedge core_clk);
      detect_strap <= 2'h3;
      wt(3 * TC);
      chk(tests, 8'h00);
      chk(term_50_q & ~input_hiz_q & driver_en_q, 1'b1);
      @(posedge core_clk);
      detect_strap <= 2'h2;
      wtest(8'd5);
      chk(tests, 8'd5);
      chk(gap, TC);
      chk(input_hiz_q & ~term_50_q, 1'b1);
      @(posedge core_clk);
      present <= 1'b1;
      wt(2 * TC + 10);
      chk(term_50_q & ~input_hiz_q, 1'b1);
      @(posedge core_clk);
      present <= 1'b0;
      pdp(2'h1);
      t0 = tests;
      wt((GT + 3) * (TC + 2) + 10);
      chk(tests, t0 + GT);
      pdp(2'h1);
      wt((GT + 3) * (TC + 2) + 10);
      chk(tests, t0 + 2 * GT);
      @(posedge core_clk);
      present <= 1'b1;
      pdp(2'h1);
      wt(2 * TC + 10);
      chk(term_50_q, 1'b1);
      pdp(2'h0);
      $display("test detect done");
      @(posedge core_clk);
      register_mode_select <= 1'b1;
      bus(1'b0, `RDOC_OFS_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0008);
      bus(1'b0, `RDOC_OFS_SWING, 32'h0000_0000);
      chk(rd, 32'h0000_00AA);
      bus(1'b0, 8'h0C, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b1, `RDOC_OFS_CTRL, 32'h0000_0003);
      wt(2);
      chk({term_50_q, signal_sense_threshold_strap_code_q}, 3'h3);
      bus(1'b1, `RDOC_OFS_CTRL, 32'h0000_0033);
      bus(1'b1, `RDOC_OFS_SWING, 32'h0000_00F0);
      wt(2);
      chk({term_50_q, signal_sense_threshold_strap_code_q}, 3'h4);
      chk({output_swing_b_q, output_swing_a_q}, 8'hD8);
      pdp(2'h0);
      bus(1'b0, `RDOC_OFS_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0033);
      // status: terminated, restart pulse seen, no tries, machine off
      bus(1'b0, `RDOC_OFS_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0070);
      @(posedge core_clk);
      register_mode_select <= 1'b0;
      wt(2);
      @(posedge core_clk);
      register_mode_select <= 1'b1;
      bus(1'b0, `RDOC_OFS_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0008);
      $display("test registers done");
      give_verdict;
   end
endmodule

// file: dv/rdoc_rx_detect_cfg_checker.sv
// assertion checker for the receiver-detect configuration block
`timescale 1ns/100ps
module rdoc_rx_detect_cfg_checker (
   // clock and reset
   input wire core_clk,
   input wire rst_b,
   // straps and pins
   input wire [1:0] detect_strap,
   input wire [1:0] driver_mode_strap,
   input wire [1:0] signal_sense_threshold_strap,
   input wire power_down_pin,
   input wire register_mode_select,
   // detect link and outputs
   input wire rx_present,
   input wire rx_test_q,
   input wire term_50_q,
   input wire input_hiz_q,
   input wire driver_en_q,
   input wire [1:0] output_emphasis_reduction_a_q,
   input wire [1:0] signal_sense_threshold_strap_code_q
);
   // pin mode while powered, manual codes, threshold strap
   wire pm = !register_mode_select && !power_down_pin;
   wire man = detect_strap[1] == detect_strap[0];
   wire [1:0] th = signal_sense_threshold_strap;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   a_pd_inputs_off: assert property (
      power_down_pin |=> input_hiz_q && !driver_en_q)
      else $error("power down left inputs or drivers on");
   a_manual_no_test: assert property (
      (pm && man) [*2] |-> !rx_test_q)
      else $error("test issued in a manual code");
   a_code0_hiz: assert property (
      (pm && detect_strap == 2'h0) [*2] |-> input_hiz_q && !term_50_q)
      else $error("code zero not high impedance");
   a_code3_term: assert property (
      (pm && detect_strap == 2'h3) [*2] |-> term_50_q && !input_hiz_q)
      else $error("code three not terminated");
   a_found_term: assert property (
      rx_test_q && rx_present && pm ##1 rx_present && pm |-> ##[0:2] term_50_q && !input_hiz_q)
      else $error("detected receiver left unterminated");
   a_test_spacing: assert property (
      rx_test_q |=> !rx_test_q [*8])
      else $error("tests too close together");
   a_restart_clear: assert property (
      $fell(power_down_pin) && !register_mode_select && !man |-> (!rx_test_q && !term_50_q) [*8])
      else $error("detect machine not restarted");
   a_th_map: assert property (
      !register_mode_select |=> signal_sense_threshold_strap_code_q == (($past(th) == 2'h3) ? 2'h3 : 2'h2 - $past(th)))
      else $error("threshold code wrong");
   a_emph_off: assert property (
      !register_mode_select && driver_mode_strap == 2'h1 |=> output_emphasis_reduction_a_q == 2'h0)
      else $error("emphasis applied in resistor mode");
endmodule
bind rdoc_rx_detect_cfg rdoc_rx_detect_cfg_checker i_rdoc_rx_detect_cfg_checker (
   .core_clk, .rst_b, .detect_strap, .driver_mode_strap, .signal_sense_threshold_strap,
   .power_down_pin, .register_mode_select, .rx_present, .rx_test_q, .term_50_q,
   .input_hiz_q, .driver_en_q, .output_emphasis_reduction_a_q, .signal_sense_threshold_strap_code_q);

// file: dv/rdoc_rx_partner.sv
// link partner model: counts receiver tests and senses presence
`timescale 1ns/100ps
module rdoc_rx_partner (
   // clock and reset
   input wire core_clk,
   input wire rst_b,
   // detect link
   input wire rx_test_q,
   input wire present,
   output wire rx_present,
   // test statistics
   output reg [7:0] tests,
   output reg [7:0] gap
);
   reg [7:0] since_q;
   // a connected receiver loads the line as a steady level
   assign rx_present = present;
   // count tests and the cycles between two of them
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tests <= 8'h00;
         gap <= 8'h00;
         since_q <= 8'h00;
      end else if (rx_test_q) begin
         tests <= tests + 8'h01;
         gap <= since_q + 8'h01;
         since_q <= 8'h00;
      end else begin
         since_q <= since_q + 8'h01; // wraps, only adjacent tests matter
      end
   end
endmodule

// file: hdl/rdoc_consts.vh
// constants for the receiver-detect and output configuration block
`ifndef RDOC_CONSTS_VH
`define RDOC_CONSTS_VH
// core clock rate and detect timing, times in their own units
`define RDOC_CLK_HZ 10000000
`define RDOC_TEST_MS 12
`define RDOC_GIVEUP_MS 600
`define RDOC_PD_PULSE_NS 5000
// derived cycle and test counts
`define RDOC_TEST_CYC ((`RDOC_TEST_MS * `RDOC_CLK_HZ) / 1000)
`define RDOC_GIVEUP_TESTS (`RDOC_GIVEUP_MS / `RDOC_TEST_MS)
`define RDOC_PD_PULSE_CYC ((`RDOC_PD_PULSE_NS * (`RDOC_CLK_HZ / 1000000) + 999) / 1000)
// four-level strap encodings as presented on the 2-bit strap inputs
`define RDOC_LVL_ZERO 2'h0
`define RDOC_LVL_RES 2'h1
`define RDOC_LVL_FLOAT 2'h2
`define RDOC_LVL_ONE 2'h3
// detect codes
`define RDOC_DET_MANUAL_HIZ 2'h0
`define RDOC_DET_AUTO_LIMITED 2'h1
`define RDOC_DET_AUTO_FOREVER 2'h2
`define RDOC_DET_MANUAL_50 2'h3
// register byte offsets
`define RDOC_OFS_CTRL 8'h00
`define RDOC_OFS_SWING 8'h04
`define RDOC_OFS_STATUS 8'h08
// control register fields
`define RDOC_CTRL_DET_LSB 0
`define RDOC_CTRL_TH_LSB 2
`define RDOC_CTRL_DET_OVRD 4
`define RDOC_CTRL_TH_OVRD 5
// swing register fields
`define RDOC_SWING_A_LSB 0
`define RDOC_SWING_B_LSB 4
// reset values
`define RDOC_CTRL_RST 8'h08
`define RDOC_SWING_RST 8'hAA
`endif

// file: hdl/rdoc_rx_detect_cfg.v
// receiver-detect control and output configuration with wishbone registers
`timescale 1ns/100ps
`include "rdoc_consts.vh"
module rdoc_rx_detect_cfg #(
   parameter TEST_CYC = `RDOC_TEST_CYC,
   parameter GIVEUP_TESTS = `RDOC_GIVEUP_TESTS
) (
   // clock and reset
   input wire core_clk,
   input wire rst_b,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // four-level straps, encoded 0:zero 1:resistor 2:float 3:one
   input wire [1:0] swing_strap_group_a_high,
   input wire [1:0] swing_strap_group_a_low,
   input wire [1:0] swing_strap_group_b_high,
   input wire [1:0] swing_strap_group_b_low,
   input wire [1:0] driver_mode_strap,
   input wire [1:0] detect_strap,
   input wire [1:0] signal_sense_threshold_strap,
   // control pins
   input wire power_down_pin,
   input wire register_mode_select,
   // receiver test on the outputs
   input wire rx_present,
   output reg rx_test_q,
   // termination and driver control
   output reg term_50_q,
   output reg input_hiz_q,
   output reg driver_en_q,
   // output settings per lane group
   output reg [3:0] output_swing_a_q,
   output reg [1:0] output_emphasis_reduction_a_q,
   output reg [3:0] output_swing_b_q,
   output reg [1:0] output_emphasis_reduction_b_q,
   // signal-detect threshold code
   output reg [1:0] signal_sense_threshold_strap_code_q
);
   // detect state machine codes
   localparam ST_OFF = 3'h0;
   localparam ST_WAIT = 3'h1;
   localparam ST_TEST = 3'h2;
   localparam ST_FOUND = 3'h3;
   localparam ST_GAVEUP = 3'h4;

   reg [7:0] ctrl_q;
   reg [7:0] swing_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [31:0] ivl_cnt_q;
   reg [7:0] tries_q;
   reg [15:0] pd_cnt_q;
   reg pd_restart_q;
   wire [1:0] det_code;
   wire [1:0] th_code;
   wire [3:0] sw_a_idx;
   wire [3:0] sw_b_idx;
   wire [3:0] map_a_swing;
   wire [1:0] map_a_emph;
   wire [3:0] map_b_swing;
   wire [1:0] map_b_emph;
   wire bus_req;
   wire auto_mode;
   wire emph_on;
   wire ivl_done;

   // threshold strap level to register code
   function [1:0] th_from_level;
      input [1:0] lvl;
      begin
         case (lvl)
            `RDOC_LVL_ZERO: th_from_level = 2'h2;
            `RDOC_LVL_RES: th_from_level = 2'h1;
            `RDOC_LVL_FLOAT: th_from_level = 2'h0;
            default: th_from_level = 2'h3;
         endcase
      end
   endfunction

   // straps stay in charge until register mode and the override bit agree
   assign det_code = (register_mode_select && ctrl_q[`RDOC_CTRL_DET_OVRD]) ?
      ctrl_q[`RDOC_CTRL_DET_LSB +: 2] : detect_strap;
   assign th_code = (register_mode_select && ctrl_q[`RDOC_CTRL_TH_OVRD]) ?
      ctrl_q[`RDOC_CTRL_TH_LSB +: 2] : th_from_level(signal_sense_threshold_strap);

   // in register mode the strap pins become addresses, so swing comes from the register
   assign sw_a_idx = register_mode_select ? swing_q[`RDOC_SWING_A_LSB +: 4] :
      {swing_strap_group_a_high, swing_strap_group_a_low};
   assign sw_b_idx = register_mode_select ? swing_q[`RDOC_SWING_B_LSB +: 4] :
      {swing_strap_group_b_high, swing_strap_group_b_low};

   rdoc_swing_map u_map_a (
      .level_idx(sw_a_idx),
      .swing_code(map_a_swing),
      .emph_code(map_a_emph)
   );

   rdoc_swing_map u_map_b (
      .level_idx(sw_b_idx),
      .swing_code(map_b_swing),
      .emph_code(map_b_emph)
   );

   // de-emphasis is dropped only in transparent-without-emphasis driver mode
   assign emph_on = (driver_mode_strap == `RDOC_LVL_ONE) ||
      (driver_mode_strap != `RDOC_LVL_RES);

   assign auto_mode = (det_code == `RDOC_DET_AUTO_LIMITED) ||
      (det_code == `RDOC_DET_AUTO_FOREVER);
   // the test cycle itself is the last cycle of an interval, so wait one less
   assign ivl_done = (ivl_cnt_q == TEST_CYC - 2);
   assign bus_req = wb_cyc_i && wb_stb_i;

   // wishbone: ack one cycle after request, write lands at the acked edge
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req && !wb_ack_o;
         if (bus_req && !wb_ack_o) begin
            case (wb_adr_i)
               `RDOC_OFS_CTRL: wb_dat_o <= {24'h00_0000, ctrl_q};
               `RDOC_OFS_SWING: wb_dat_o <= {24'h00_0000, swing_q};
               `RDOC_OFS_STATUS: wb_dat_o <= {24'h00_0000, power_down_pin, term_50_q,
                  pd_restart_q, tries_q[4:0] == 5'h00, 1'b0, state_q};
               default: wb_dat_o <= 32'h0000_0000; // unmapped reads as zero
            endcase
         end
      end
   end

   // config registers; power-down leaves them alone, mode-select low reloads their reset values
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= `RDOC_CTRL_RST;
         swing_q <= `RDOC_SWING_RST;
      end else if (!register_mode_select) begin
         ctrl_q <= `RDOC_CTRL_RST;
         swing_q <= `RDOC_SWING_RST;
      end else if (bus_req && wb_ack_o && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == `RDOC_OFS_CTRL) begin
            ctrl_q <= {2'h0, wb_dat_i[5:0]};
         end
         if (wb_adr_i == `RDOC_OFS_SWING) begin
            swing_q <= wb_dat_i[7:0];
         end
      end
   end

   // power-down pulse width monitor; a pulse of full length flags a restart
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pd_cnt_q <= 16'h0000;
         pd_restart_q <= 1'b0;
      end else if (power_down_pin) begin
         if (pd_cnt_q != 16'hFFFF) begin
            pd_cnt_q <= pd_cnt_q + 16'h0001;
         end
      end else begin
         pd_cnt_q <= 16'h0000;
         if (pd_cnt_q >= `RDOC_PD_PULSE_CYC) begin
            pd_restart_q <= 1'b1;
         end else if (state_q == ST_FOUND) begin
            pd_restart_q <= 1'b0;
         end
      end
   end

   // detect state machine next state
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (auto_mode) begin
               state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!auto_mode) begin
               state_d = ST_OFF;
            end else if (ivl_done) begin
               state_d = ST_TEST;
            end
         end
         ST_TEST: begin
            if (rx_present) begin
               state_d = ST_FOUND;
            end else if (det_code == `RDOC_DET_AUTO_LIMITED &&
                  tries_q >= GIVEUP_TESTS - 1) begin
               state_d = ST_GAVEUP;
            end else begin
               state_d = ST_WAIT;
            end
         end
         ST_FOUND: begin
            if (!auto_mode) begin
               state_d = ST_OFF;
            end
         end
         ST_GAVEUP: begin
            if (!auto_mode) begin
               state_d = ST_OFF;
            end
         end
         default: state_d = ST_OFF;
      endcase
   end

   // state, interval counter and try count; power-down restarts all of it
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_OFF;
         ivl_cnt_q <= 32'h0000_0000;
         tries_q <= 8'h00;
      end else if (power_down_pin) begin
         state_q <= ST_OFF;
         ivl_cnt_q <= 32'h0000_0000;
         tries_q <= 8'h00;
      end else begin
         state_q <= state_d;
         if (state_q == ST_WAIT && !ivl_done) begin
            ivl_cnt_q <= ivl_cnt_q + 32'h0000_0001;
         end else begin
            ivl_cnt_q <= 32'h0000_0000;
         end
         if (state_q == ST_OFF) begin
            tries_q <= 8'h00;
         end else if (state_q == ST_TEST && tries_q != 8'hFF) begin
            tries_q <= tries_q + 8'h01;
         end
      end
   end

   // pin outputs registered so they never glitch onto the analog controls
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_test_q <= 1'b0;
         term_50_q <= 1'b0;
         input_hiz_q <= 1'b1;
         driver_en_q <= 1'b0;
         output_swing_a_q <= 4'h0;
         output_emphasis_reduction_a_q <= 2'h0;
         output_swing_b_q <= 4'h0;
         output_emphasis_reduction_b_q <= 2'h0;
         signal_sense_threshold_strap_code_q <= 2'h0;
      end else begin
         rx_test_q <= !power_down_pin && state_d == ST_TEST && state_q == ST_WAIT;
         if (power_down_pin) begin
            term_50_q <= 1'b0;
            input_hiz_q <= 1'b1;
            driver_en_q <= 1'b0;
         end else if (det_code == `RDOC_DET_MANUAL_50) begin
            term_50_q <= 1'b1;
            input_hiz_q <= 1'b0;
            driver_en_q <= 1'b1;
         end else if (auto_mode) begin
            term_50_q <= state_q == ST_FOUND;
            input_hiz_q <= state_q != ST_FOUND;
            driver_en_q <= 1'b1;
         end else begin
            term_50_q <= 1'b0;
            input_hiz_q <= 1'b1;
            driver_en_q <= 1'b1;
         end
         output_swing_a_q <= map_a_swing;
         output_swing_b_q <= map_b_swing;
         output_emphasis_reduction_a_q <= emph_on ? map_a_emph : 2'h0;
         output_emphasis_reduction_b_q <= emph_on ? map_b_emph : 2'h0;
         signal_sense_threshold_strap_code_q <= th_code;
      end
   end
endmodule

// file: hdl/rdoc_swing_map.v
// maps a strap level pair to output swing and emphasis reduction codes
`timescale 1ns/100ps
module rdoc_swing_map (
   // level pair {high strap, low strap}
   input wire [3:0] level_idx,
   // swing in 100 mV steps and emphasis code (0:0 dB 1:-3.5 2:-6 3:-9)
   output reg [3:0] swing_code,
   output reg [1:0] emph_code
);
   // sixteen settings from 0.8 V flat up to 1.3 V at -9 dB
   always @* begin
      swing_code = 4'h8;
      emph_code = 2'h0;
      case (level_idx)
         4'h0: begin swing_code = 4'h8; emph_code = 2'h0; end
         4'h1: begin swing_code = 4'h9; emph_code = 2'h0; end
         4'h2: begin swing_code = 4'h9; emph_code = 2'h1; end
         4'h3: begin swing_code = 4'hA; emph_code = 2'h0; end
         4'h4: begin swing_code = 4'hA; emph_code = 2'h1; end
         4'h5: begin swing_code = 4'hA; emph_code = 2'h2; end
         4'h6: begin swing_code = 4'hB; emph_code = 2'h0; end
         4'h7: begin swing_code = 4'hB; emph_code = 2'h1; end
         4'h8: begin swing_code = 4'hB; emph_code = 2'h2; end
         4'h9: begin swing_code = 4'hC; emph_code = 2'h0; end
         4'hA: begin swing_code = 4'hC; emph_code = 2'h1; end
         4'hB: begin swing_code = 4'hC; emph_code = 2'h2; end
         4'hC: begin swing_code = 4'hD; emph_code = 2'h0; end
         4'hD: begin swing_code = 4'hD; emph_code = 2'h1; end
         4'hE: begin swing_code = 4'hD; emph_code = 2'h2; end
         default: begin swing_code = 4'hD; emph_code = 2'h3; end
      endcase
   end
endmodule
